// file: design/asrp_regs.svh
// Constants for the serial readout port: widths, timing and codes.
// Assumes inclusion by bare name from the design files only.
`ifndef ASRP_REGS_SVH
`define ASRP_REGS_SVH
`define ASRP_RESULT_BITS 16
`define ASRP_CHAIN_DELAY 16
`define ASRP_CONV_TIME_NS 500
`define ASRP_CLK_PERIOD_NS 8
`define ASRP_CONV_CYCLES ((`ASRP_CONV_TIME_NS + `ASRP_CLK_PERIOD_NS - 1) / `ASRP_CLK_PERIOD_NS)
`define ASRP_CODE_FULL 16'hffff
`define ASRP_CODE_ZERO 16'h0000
`endif

// file: design/asrp_pkg.sv
// Types shared by the serial readout port.
// Assumes the constants header is on the include path.
`include "asrp_regs.svh"
package asrp_pkg;
  typedef enum logic [1:0] {
    ASRP_IDLE = 2'b00,
    ASRP_CONV = 2'b01,
    ASRP_READ = 2'b10
  } asrp_state_t;
  typedef enum logic {
    ASRP_MODE_SELECT = 1'b0,
    ASRP_MODE_CHAIN = 1'b1
  } asrp_mode_t;
  typedef struct packed {
    logic convert_strobe;
    logic shift_clk;
    logic chain_serial_in;
  } asrp_pins_t;
  typedef struct packed {
    logic out;
    logic oe_n;
  } asrp_sdo_t;
endpackage

// file: design/asrp_sync.sv
// Three-stage pin synchroniser for a packed group of pins.
// Assumes asynchronous inputs; outputs only change when stages two and three agree.
`timescale 1ns/1ps
module asrp_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [WIDTH-1:0] nxt_out;
  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end
  assign pin_out = out_ff;
  initial begin
    if (WIDTH < 1) begin
      $error("asrp_sync: WIDTH must be at least 1");
    end
  end
endmodule

// file: design/asrp_port.sv
// Serial readout port of a 16-bit sampling converter.
// Assumes pins arrive asynchronously and are sampled on clk_sys; the host
// makes the shift clock and drives the convert strobe and chain input.
`timescale 1ns/1ps
`include "asrp_regs.svh"
module asrp_port
  import asrp_pkg::*;
#(
  parameter int RESULT_BITS = `ASRP_RESULT_BITS,
  parameter int CONV_CYCLES = `ASRP_CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic convert_strobe,
  input wire logic shift_clk,
  input wire logic chain_serial_in,
  input wire logic [RESULT_BITS-1:0] sample_code,
  input wire logic sample_over,
  input wire logic sample_under,
  output logic result_serial_out,
  output logic result_serial_oe_n,
  output logic conv_busy,
  output logic chain_mode
);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  asrp_pins_t pins_raw, pins;
  assign pins_raw = '{convert_strobe: convert_strobe, shift_clk: shift_clk,
                      chain_serial_in: chain_serial_in};
  asrp_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  function automatic logic [RESULT_BITS-1:0] clamp_code(
    input logic [RESULT_BITS-1:0] code, input logic over, input logic under);
    if (over) begin
      clamp_code = '1;
    end else if (under) begin
      clamp_code = '0;
    end else begin
      clamp_code = code;
    end
  endfunction

  // Control group: conversion sequencing and the mode latched at its start.
  asrp_state_t state_ff, nxt_state;
  asrp_mode_t mode_ff, nxt_mode;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic conv_busy_ff, nxt_conv_busy;
  // Edge group: last synchronised level of the two clocking pins.
  logic cnv_d_ff, nxt_cnv_d;
  logic sck_d_ff, nxt_sck_d;
  // Data group: result shifter, serial output and pending busy indicator.
  logic [RESULT_BITS-1:0] shreg_ff, nxt_shreg;
  logic sdo_ff, nxt_sdo;
  logic busy_ff, nxt_busy;
  // Enable group: serial output driver.
  logic oe_n_ff, nxt_oe_n;
  logic cnv_rise, sck_rise, sck_fall, sel_low, conv_end, reading, chain_bit;

  function automatic logic edge_seen(
    input logic now_lvl, input logic old_lvl, input logic rising);
    if (rising) begin
      edge_seen = now_lvl & ~old_lvl;
    end else begin
      edge_seen = ~now_lvl & old_lvl;
    end
  endfunction

  assign cnv_rise = edge_seen(pins.convert_strobe, cnv_d_ff, 1'b1);
  assign sck_rise = edge_seen(pins.shift_clk, sck_d_ff, 1'b1);
  assign sck_fall = edge_seen(pins.shift_clk, sck_d_ff, 1'b0);
  assign sel_low = ~pins.convert_strobe | ~pins.chain_serial_in;
  assign conv_end = (state_ff == ASRP_CONV) && (cnt_ff == '0);
  assign reading = (state_ff == ASRP_READ);
  // Only chain mode feeds the upstream stream into the shifter tail.
  assign chain_bit = (mode_ff == ASRP_MODE_CHAIN) & pins.chain_serial_in;

  always_comb begin
    nxt_cnv_d = pins.convert_strobe;
    nxt_sck_d = pins.shift_clk;
  end

  // Reset levels match the idle pins, so no false edge follows reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnv_d_ff <= 1'b0;
      sck_d_ff <= 1'b0;
    end else begin
      cnv_d_ff <= nxt_cnv_d;
      sck_d_ff <= nxt_sck_d;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ASRP_IDLE, ASRP_READ: begin
        // Outside a conversion a strobe rise restarts; inside one it is ignored.
        if (cnv_rise) begin
          // Mode and conversion start share the same strobe edge.
          nxt_mode = pins.chain_serial_in ? ASRP_MODE_SELECT : ASRP_MODE_CHAIN;
          nxt_state = ASRP_CONV;
          nxt_cnt = CW'(CONV_CYCLES);
        end
      end
      ASRP_CONV: begin
        // Counted on clk_sys alone, the shift clock plays no part.
        if (cnt_ff == '0) begin
          nxt_state = ASRP_READ;
        end else begin
          nxt_cnt = cnt_ff - CW'(1);
        end
      end
      default: begin
        nxt_state = ASRP_IDLE;
      end
    endcase
    nxt_conv_busy = (nxt_state == ASRP_CONV);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= ASRP_IDLE;
      mode_ff <= ASRP_MODE_SELECT;
      cnt_ff <= '0;
      conv_busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      conv_busy_ff <= nxt_conv_busy;
    end
  end

  always_comb begin
    nxt_shreg = shreg_ff;
    nxt_sdo = sdo_ff;
    nxt_busy = busy_ff;
    if (state_ff == ASRP_CONV) begin
      if (conv_end) begin
        nxt_shreg = clamp_code(sample_code, sample_over, sample_under);
        // In select mode, either select pin low at the end arms the busy indicator.
        nxt_busy = (mode_ff == ASRP_MODE_SELECT) && sel_low;
        // The indicator falls to flag data ready; otherwise the MSB shows now.
        nxt_sdo = nxt_busy ? 1'b0 : nxt_shreg[RESULT_BITS-1];
      end else begin
        // While converting the output stands high, ready to fall at the end.
        nxt_sdo = 1'b1;
      end
    end else if (cnv_rise) begin
      // A new conversion drops an indicator that no shift clock has answered.
      nxt_busy = 1'b0;
    end else if (reading && busy_ff) begin
      // The first fall after the indicator presents the MSB unshifted.
      if (sck_fall) begin
        nxt_sdo = shreg_ff[RESULT_BITS-1];
        nxt_busy = 1'b0;
      end
    end else if (reading) begin
      // Shift on the rise, present on the fall, MSB first.
      if (sck_rise) begin
        // The chain bit enters the tail, so it exits 16 clocks later.
        nxt_shreg = {shreg_ff[RESULT_BITS-2:0], chain_bit};
      end
      if (sck_fall) begin
        nxt_sdo = shreg_ff[RESULT_BITS-1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shreg_ff <= '0;
      sdo_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      shreg_ff <= nxt_shreg;
      sdo_ff <= nxt_sdo;
      busy_ff <= nxt_busy;
    end
  end

  always_comb begin
    // Chain mode drives always; select mode drives while either select pin is low.
    if (mode_ff == ASRP_MODE_CHAIN) begin
      nxt_oe_n = 1'b0;
    end else begin
      nxt_oe_n = ~sel_low;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign result_serial_out = sdo_ff;
  assign result_serial_oe_n = oe_n_ff;
  assign conv_busy = conv_busy_ff;
  assign chain_mode = mode_ff;

  // The chain delay is the shifter length, so the two must stay equal.
  initial begin
    if (RESULT_BITS < 2 || CONV_CYCLES < 1 || RESULT_BITS != `ASRP_CHAIN_DELAY) begin
      $error("asrp_port: RESULT_BITS must equal the chain delay, CONV_CYCLES >= 1");
    end
  end
endmodule

// file: testbench/asrp_port_chk.sv
// Pin-level assertions for the readout port.
// Assumes binding to asrp_port built with CONV_CYCLES of 4.
`timescale 1ns/1ps
module asrp_port_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic convert_strobe,
  input wire logic chain_serial_in,
  input wire logic result_serial_out,
  input wire logic result_serial_oe_n,
  input wire logic conv_busy,
  input wire logic chain_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_conv;
    conv_busy [*5] ##1 !conv_busy;
  endsequence
  sequence s_sel_idle;
    (!chain_mode && convert_strobe && chain_serial_in) [*8];
  endsequence
  a_conv_len: assert property ($rose(conv_busy) |-> s_conv)
    else $error("conversion length wrong");
  a_mode_hold: assert property (!$rose(conv_busy) |-> $stable(chain_mode))
    else $error("mode changed outside a conversion start");
  a_start_cause: assert property ($rose(conv_busy) |-> $past(convert_strobe, 3))
    else $error("conversion started without a strobe");
  a_mode_source: assert property ($rose(conv_busy) |-> chain_mode == !$past(chain_serial_in, 3))
    else $error("mode does not follow chain input");
  a_chain_drive: assert property (chain_mode |-> !result_serial_oe_n)
    else $error("chain mode output not driven");
  a_sel_hiz: assert property (s_sel_idle |-> result_serial_oe_n)
    else $error("output driven while deselected");
  a_sel_drive: assert property ((!chain_mode && !convert_strobe) [*8] |-> !result_serial_oe_n)
    else $error("output not driven while selected");
  a_conv_high: assert property (conv_busy && $past(conv_busy) |-> result_serial_out)
    else $error("output not high during conversion");
  a_rst_values: assert property (disable iff (1'b0)
    sys_rst |=> result_serial_oe_n && !conv_busy && !chain_mode && !result_serial_out)
    else $error("reset values wrong");
endmodule

// file: testbench/asrp_host_model.sv
// Host model driving the strobe, shift clock and chain input.
// Assumes clk_sys of 8 ns; the shift clock idles low between frames.
`timescale 1ns/1ps
module asrp_host_model (
  input wire logic clk_sys,
  input wire logic sdo_line,
  output logic convert_strobe,
  output logic shift_clk,
  output logic chain_serial_in
);
  initial begin
    convert_strobe = 1'b0;
    shift_clk = 1'b0;
    chain_serial_in = 1'b1;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic convert(logic chain, logic busy_ind);
    convert_strobe = 1'b0;
    chain_serial_in = !chain;
    tick(8);
    convert_strobe = 1'b1;
    if (busy_ind) begin
      // Dropping the strobe before the conversion ends arms the indicator.
      tick(3);
      convert_strobe = 1'b0;
      tick(21);
    end else begin
      tick(24);
    end
  endtask
  // Data is sampled just before each fall, since the port answers a fall late.
  task automatic read(int n, logic chain, logic [15:0] up, output logic [31:0] got);
    got = '0;
    if (!chain) convert_strobe = 1'b0;
    tick(8);
    for (int i = 0; i < n; i++) begin
      if (chain) chain_serial_in = up[15 - i % 16];
      shift_clk = 1'b1;
      tick(4);
      got = {got[30:0], sdo_line};
      shift_clk = 1'b0;
      tick(4);
    end
  endtask
endmodule

// file: testbench/asrp_port_tb.sv
// Bench for the readout port: random codes read in both modes.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module asrp_port_tb import asrp_pkg::*;;
  logic clk_sys = 1'b0, sys_rst = 1'b1, sample_over = 1'b0, sample_under = 1'b0, chain, bsy;
  logic [15:0] sample_code = 16'h0000, up, exp_word;
  logic [2:0] exp_st;
  logic [31:0] got;
  logic convert_strobe, shift_clk, chain_serial_in, result_serial_out, result_serial_oe_n;
  logic conv_busy, chain_mode;
  int errors = 0, samples_checked = 0, seed = 32'h6f92a3d3;
  wire sdo_line = result_serial_oe_n ? 1'bz : result_serial_out;
  always #4 clk_sys = ~clk_sys;
  asrp_port #(.CONV_CYCLES(4)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .chain_serial_in(chain_serial_in), .sample_code(sample_code),
    .sample_over(sample_over), .sample_under(sample_under),
    .result_serial_out(result_serial_out), .result_serial_oe_n(result_serial_oe_n),
    .conv_busy(conv_busy), .chain_mode(chain_mode));
  asrp_host_model u_host (.clk_sys(clk_sys), .sdo_line(sdo_line),
    .convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .chain_serial_in(chain_serial_in));
  task automatic chk(logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_status(logic [2:0] g, logic [2:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] exp_code(logic [15:0] c, logic o, logic u);
    return o ? 16'hffff : (u ? 16'h0000 : c);
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      chain = i[0];
      // Select-mode rounds 2, 6 and 10 drop the strobe early to use the indicator.
      bsy = !chain && i[1];
      sample_code = 16'($random(seed));
      sample_over = (i == 2) || (i == 4) || (i == 5);
      sample_under = (i == 3) || (i == 4);
      up = 16'($random(seed));
      exp_word = exp_code(sample_code, sample_over, sample_under);
      exp_st = {chain, !chain && !bsy, !bsy && exp_word[15]};
      u_host.convert(chain, bsy);
      chk_status({chain_mode, result_serial_oe_n, result_serial_out}, exp_st);
      u_host.read(chain ? 32 : (bsy ? 17 : 16), chain, up, got);
      chk(got, chain ? {exp_word, up} : {16'h0000, exp_word});
    end
    tally_and_finish();
  end
endmodule
bind asrp_port asrp_port_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .convert_strobe(convert_strobe), .chain_serial_in(chain_serial_in),
  .result_serial_out(result_serial_out), .result_serial_oe_n(result_serial_oe_n),
  .conv_busy(conv_busy), .chain_mode(chain_mode));
